// ===== rtl/btsc_exec.sv
// Execution unit for bit-test skips, indirect call and accumulator clear
`timescale 1ns/1ps
`include "btsc_params.svh"
// Overview of operation
// RULE_01 - Skip-if-clear test skips next instruction when selected bit is zero.
// RULE_02 - Skip-if-set test skips next instruction when selected bit is one.
// RULE_03 - Skip replaces fetched next instruction with no-op; one or two cycles.
// RULE_04 - Register address 0..127, bit 0..7; no status flag changes for tests.
// RULE_05 - Indirect call pushes program counter plus one onto return stack.
// RULE_06 - Call loads PC high from table pointer low bits, PC low from accumulator.
// RULE_07 - Clear accumulator writes zero and sets zero flag, one cycle.
// RULE_08 - Indirect call increments stack pointer and takes two cycles.
module btsc_exec (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Instruction issue
  input wire logic ISSUE,
  input wire btsc_pkg::btsc_instr_t INSTR,
  // Core state inputs
  input wire logic [7:0] RF_RDATA,
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] TABLE_HIGH_POINTER,
  input wire logic ZERO_IN,
  // Register file address
  output logic [6:0] RF_ADDR,
  // Control outputs
  output logic BUSY,
  output logic SQUASH_NEXT,
  output logic [10:0] PC,
  output logic [2:0] SP,
  output btsc_pkg::btsc_push_t PUSH,
  output logic [7:0] ACC,
  output logic ZERO
);
  typedef enum logic [1:0] {BTSC_ST_RUN, BTSC_ST_NOP, BTSC_ST_CALL2} btsc_state_t;

  btsc_state_t state_q;
  btsc_state_t state_d;
  logic sel_bit;
  logic take_skip;
  logic go;
  logic [10:0] pc_q;
  logic [2:0] sp_q;
  logic [7:0] acc_q;
  logic zero_q;
  btsc_pkg::btsc_push_t push_q;

  // ==========================================================
  // Operand fetch
  assign RF_ADDR = INSTR.reg_addr; // see RULE_04

  btsc_bitsel u_bitsel (
    .data(RF_RDATA),
    .sel(INSTR.bit_sel),
    .bit_out(sel_bit)
  );

  // New issues only accepted in the run state
  // A refused issue gives no indication; the core must wait out BUSY
  assign go = ISSUE && (state_q == BTSC_ST_RUN);

  // Skip decision for both tests
  always_comb begin
    take_skip = 1'b0;
    if (go && INSTR.op == btsc_pkg::BTSC_OP_SKIP_CLR) begin
      take_skip = (sel_bit == 1'b0); // see RULE_01
    end else if (go && INSTR.op == btsc_pkg::BTSC_OP_SKIP_SET) begin
      take_skip = (sel_bit == 1'b1); // see RULE_02
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      BTSC_ST_RUN: begin
        if (take_skip) begin
          state_d = BTSC_ST_NOP; // see RULE_03
        end else if (go && INSTR.op == btsc_pkg::BTSC_OP_CALL) begin
          state_d = BTSC_ST_CALL2; // see RULE_08
        end
      end
      BTSC_ST_NOP: state_d = BTSC_ST_RUN;
      BTSC_ST_CALL2: state_d = BTSC_ST_RUN;
      default: state_d = BTSC_ST_RUN;
    endcase
  end

  // State register; a refused issue never reaches it
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= BTSC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Discarded slot executes as a no-op
  assign SQUASH_NEXT = (state_q == BTSC_ST_NOP); // see RULE_03
  assign BUSY = (state_q != BTSC_ST_RUN);

  // ==========================================================
  // Program counter: plain step, or jump on indirect call
  // The call's busy slot holds PC; the no-op slot steps past the discarded word
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pc_q <= `BTSC_PC_RST;
    end else if (go && INSTR.op == btsc_pkg::BTSC_OP_CALL) begin
      pc_q <= {TABLE_HIGH_POINTER[`BTSC_TBL_HI_MSB:0], ACC_IN}; // see RULE_06
    end else if (go || state_q == BTSC_ST_NOP) begin
      pc_q <= pc_q + `BTSC_PC_STEP;
    end
  end

  // Return push and stack pointer advance
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      push_q <= '0;
      sp_q <= `BTSC_SP_RST;
    end else if (go && INSTR.op == btsc_pkg::BTSC_OP_CALL) begin
      push_q.push <= 1'b1;
      push_q.data <= pc_q + `BTSC_PC_STEP; // see RULE_05
      sp_q <= sp_q + `BTSC_SP_STEP; // see RULE_08
    end else begin
      push_q.push <= 1'b0;
    end
  end

  // ==========================================================
  // Accumulator and zero flag; tests and call leave the flag alone
  // ACC follows the core in every cycle but an accepted clear, so a clear offered while busy has no effect
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      acc_q <= `BTSC_ACC_ZERO;
      zero_q <= 1'b0;
    end else if (go && INSTR.op == btsc_pkg::BTSC_OP_CLEAR_ACCUMULATOR_OP) begin
      acc_q <= `BTSC_ACC_ZERO; // see RULE_07
      zero_q <= 1'b1; // see RULE_07
    end else begin
      acc_q <= ACC_IN;
      zero_q <= ZERO_IN; // see RULE_04
    end
  end

  // Data outputs straight from flip-flops
  assign PC = pc_q;
  assign SP = sp_q;
  assign PUSH = push_q;
  assign ACC = acc_q;
  assign ZERO = zero_q;

  // ==========================================================
  // Checks
  sequence s_call_issue;
    ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_CALL;
  endsequence

  sequence s_call_done;
    BUSY ##1 !BUSY;
  endsequence

  // Issue of the set test and the accumulator clear, seen only while the unit is idle
  sequence s_set_issue;
    ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_SET;
  endsequence

  sequence s_clear_accumulator_op_issue;
    ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_CLEAR_ACCUMULATOR_OP;
  endsequence

  AST_SKIP_CLR: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_01
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_CLR && !RF_RDATA[INSTR.bit_sel])
    |=> SQUASH_NEXT) else $error("clear test did not skip");
  AST_SKIP_SET: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_02
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_SET && RF_RDATA[INSTR.bit_sel])
    |=> SQUASH_NEXT) else $error("set test did not skip");
  AST_NO_SKIP: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_03
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_SET && !RF_RDATA[INSTR.bit_sel])
    |=> !BUSY) else $error("skip without cause");
  AST_SKIP_LEN: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_03
    SQUASH_NEXT |=> !BUSY) else $error("skip slot longer than one cycle");
  AST_TEST_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_04
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_CLR) |=> ZERO == $past(ZERO_IN))
    else $error("bit test changed zero flag");
  AST_CALL_PUSH: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_05
    s_call_issue |=> PUSH.push && PUSH.data == $past(PC) + 11'h001)
    else $error("wrong return address");
  AST_CALL_PC: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_06
    s_call_issue |=> PC == {$past(TABLE_HIGH_POINTER[2:0]), $past(ACC_IN)})
    else $error("wrong call target");
  AST_CLEAR_ACCUMULATOR_OP: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_07
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_CLEAR_ACCUMULATOR_OP) |=> ACC == 8'h00 && ZERO && !BUSY)
    else $error("accumulator clear failed");
  AST_CALL_SP: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_08
    s_call_issue |=> SP == $past(SP) + 3'h1) else $error("stack pointer not advanced");
  AST_CALL_LEN: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_08
    s_call_issue |=> s_call_done) else $error("call not two cycles");
  AST_NO_SKIP_CLR: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_01
    (ISSUE && !BUSY && INSTR.op == btsc_pkg::BTSC_OP_SKIP_CLR && RF_RDATA[INSTR.bit_sel])
    |=> !BUSY && !SQUASH_NEXT) else $error("clear test skipped on a set bit");
  AST_SET_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_04
    s_set_issue |=> ZERO == $past(ZERO_IN))
    else $error("set test changed zero flag");
  AST_CALL_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_06
    s_call_issue |=> ZERO == $past(ZERO_IN))
    else $error("call changed zero flag");
  AST_SKIP_PC: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_03
    SQUASH_NEXT |=> PC == $past(PC) + 11'h001)
    else $error("no-op slot did not step PC");
  AST_CALL_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_08
    (BUSY && !SQUASH_NEXT) |=> PC == $past(PC))
    else $error("PC moved in call busy slot");
  AST_CLEAR_ACCUMULATOR_OP_PC: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_07
    s_clear_accumulator_op_issue |=> PC == $past(PC) + 11'h001)
    else $error("clear took more than one cycle");
  AST_PUSH_LEN: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_05
    PUSH.push |=> !PUSH.push) else $error("push held longer than one cycle");
  AST_BUSY_ONE: assert property (@(posedge CLOCK) disable iff (!RST_B) // see RULE_03
    BUSY |=> !BUSY) else $error("busy longer than one cycle");
endmodule : btsc_exec

// ===== rtl/btsc_params.svh
// Constants for the bit-test, indirect call and clear-accumulator execution unit
`ifndef BTSC_PARAMS_SVH
`define BTSC_PARAMS_SVH
`define BTSC_PC_W 11
`define BTSC_ADDR_W 7
`define BTSC_SP_W 3
`define BTSC_PC_HI_MSB 10
`define BTSC_PC_HI_LSB 8
`define BTSC_TBL_HI_MSB 2
`define BTSC_ACC_ZERO 8'h00
`define BTSC_PC_RST 11'h000
`define BTSC_SP_RST 3'h0
`define BTSC_PC_STEP 11'h001
`define BTSC_SP_STEP 3'h1
`endif

// ===== rtl/btsc_pkg.sv
// Types shared by the execution unit
package btsc_pkg;
  typedef enum logic [2:0] {
    BTSC_OP_NONE,
    BTSC_OP_SKIP_CLR,
    BTSC_OP_SKIP_SET,
    BTSC_OP_CALL,
    BTSC_OP_CLEAR_ACCUMULATOR_OP
  } btsc_op_t;
  typedef struct packed {
    btsc_op_t op;
    logic [6:0] reg_addr;
    logic [2:0] bit_sel;
  } btsc_instr_t;
  typedef struct packed {
    logic push;
    logic [10:0] data;
  } btsc_push_t;
endpackage : btsc_pkg

// ===== rtl/btsc_bitsel.sv
// Bit selector for the register-file operand
`timescale 1ns/1ps
module btsc_bitsel (
  // Operand
  input wire logic [7:0] data,
  input wire logic [2:0] sel,
  // Result
  output logic bit_out
);
  // Any position 0..7 is legal
  assign bit_out = data[sel];
endmodule : btsc_bitsel

// ===== verif/tb.sv
// Self-checking bench for the bit-test, indirect call and clear execution unit
`timescale 1ns/1ps
module tb;
  // ==========
  // Signals
  logic CLOCK, RST_B, ISSUE, ZERO_IN, BUSY, SQUASH_NEXT, ZERO;
  btsc_pkg::btsc_instr_t INSTR;
  logic [7:0] RF_RDATA, ACC_IN, TABLE_HIGH_POINTER, ACC;
  logic [6:0] RF_ADDR;
  logic [10:0] PC, pc_e;
  logic [2:0] SP, sp_e;
  btsc_pkg::btsc_push_t PUSH;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  btsc_exec uut (.CLOCK(CLOCK), .RST_B(RST_B), .ISSUE(ISSUE), .INSTR(INSTR),
    .RF_RDATA(RF_RDATA), .ACC_IN(ACC_IN), .TABLE_HIGH_POINTER(TABLE_HIGH_POINTER),
    .ZERO_IN(ZERO_IN), .RF_ADDR(RF_ADDR), .BUSY(BUSY), .SQUASH_NEXT(SQUASH_NEXT),
    .PC(PC), .SP(SP), .PUSH(PUSH), .ACC(ACC), .ZERO(ZERO));
  // ==========
  // Clock and hang guard; the run needs well under a hundred cycles
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bit test or single-cycle op; sk says whether a NOP slot must follow
  // Starts one edge on, so ISSUE is never lowered and raised in one step
  task automatic step(input btsc_pkg::btsc_op_t op, input logic [6:0] a,
                      input logic [2:0] b, input logic [7:0] rf, input logic sk);
    @(posedge CLOCK);
    #1 INSTR = '{op, a, b};
    RF_RDATA = rf;
    ISSUE = 1'b1;
    #1 chk(RF_ADDR, a);
    @(posedge CLOCK);
    #1 ISSUE = 1'b0;
    pc_e = pc_e + 11'h001;
    chk(PC, pc_e);
    chk(SQUASH_NEXT, sk);
    chk(BUSY, sk);
    if (sk) begin
      @(posedge CLOCK);
      #1 pc_e = pc_e + 11'h001;
      chk(PC, pc_e);
      chk(BUSY, 1'b0);
    end
  endtask : step
  // Indirect call; a CLEAR_ACCUMULATOR_OP offered in its busy cycle must be ignored
  task automatic call_t(input logic [7:0] acc, input logic [7:0] thp);
    logic [10:0] ret;
    @(posedge CLOCK);
    #1 ret = pc_e + 11'h001;
    ACC_IN = acc;
    TABLE_HIGH_POINTER = thp;
    INSTR = '{btsc_pkg::BTSC_OP_CALL, 7'h00, 3'h0};
    ISSUE = 1'b1;
    @(posedge CLOCK);
    #1 INSTR = '{btsc_pkg::BTSC_OP_CLEAR_ACCUMULATOR_OP, 7'h00, 3'h0};
    pc_e = {thp[2:0], acc};
    sp_e = sp_e + 3'h1;
    chk(PC, pc_e);
    chk(PUSH, {1'b1, ret});
    chk(SP, sp_e);
    chk(BUSY, 1'b1);
    @(posedge CLOCK);
    #1 ISSUE = 1'b0;
    chk(BUSY, 1'b0);
    chk(PC, pc_e);
    chk(ACC, acc);
    chk(PUSH.push, 1'b0);
  endtask : call_t
  // Scenarios, one per instruction kind
  task automatic t_skip_clr();
    step(btsc_pkg::BTSC_OP_SKIP_CLR, 7'h7F, 3'h7, 8'h7F, 1'b1);
    step(btsc_pkg::BTSC_OP_SKIP_CLR, 7'h00, 3'h0, 8'h01, 1'b0);
  endtask : t_skip_clr
  task automatic t_skip_set();
    step(btsc_pkg::BTSC_OP_SKIP_SET, 7'h7F, 3'h7, 8'h80, 1'b1);
    step(btsc_pkg::BTSC_OP_SKIP_SET, 7'h2A, 3'h3, 8'hF7, 1'b0);
    chk(ZERO, 1'b1);
  endtask : t_skip_set
  task automatic t_clear_accumulator_op();
    ZERO_IN = 1'b0;
    step(btsc_pkg::BTSC_OP_CLEAR_ACCUMULATOR_OP, 7'h00, 3'h0, 8'h00, 1'b0);
    chk(ACC, 8'h00);
    chk(ZERO, 1'b1);
  endtask : t_clear_accumulator_op
  // Two calls one idle edge apart; SP and PC keep advancing
  task automatic t_calls();
    call_t(8'h34, 8'hFA);
    call_t(8'hC3, 8'h05);
  endtask : t_calls
  // Reset in mid-run must return every register to its idle value
  task automatic t_reset();
    @(posedge CLOCK);
    #1 RST_B = 1'b0;
    #1 chk(PC, 11'h000);
    chk(SP, 3'h0);
    chk(PUSH, 12'h000);
    chk({ACC, ZERO, BUSY, SQUASH_NEXT}, 11'h000);
    @(posedge CLOCK);
    #1 RST_B = 1'b1;
    pc_e = 11'h000;
    sp_e = 3'h0;
  endtask : t_reset
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // ==========
  // Main sequence
  initial begin
    RST_B = 1'b0;
    ISSUE = 1'b0;
    INSTR = '0;
    RF_RDATA = 8'h00;
    ACC_IN = 8'h55;
    TABLE_HIGH_POINTER = 8'h00;
    ZERO_IN = 1'b1;
    pc_e = 11'h000;
    sp_e = 3'h0;
    repeat (16) @(posedge CLOCK);
    #1 RST_B = 1'b1;
    chk(PC, pc_e);
    t_skip_clr();
    t_skip_set();
    t_clear_accumulator_op();
    t_calls();
    t_reset();
    t_calls();
    results();
  end
endmodule : tb
